/* hdl/msc_cfg.svh */
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH

`define MSC_ADDR_STATUS 8'h00
`define MSC_ADDR_FLAGS  8'h04
`define MSC_ADDR_CTRL   8'h08
`define MSC_ADDR_MASK   8'h0C

`define MSC_ST_NRDY     0
`define MSC_ST_HIGH     1
`define MSC_ST_HWMODE   2

`define MSC_FLG_DONE    0
`define MSC_FLG_FAULT   1
`define MSC_FLG_PWR     2
`define MSC_FLG_W       3

`define MSC_CTRL_HPEN   0

`define MSC_CTRL_RST    1'h0
`define MSC_MASK_RST    3'h7
`define MSC_FLAGS_RST   3'h0
`define MSC_SYNC_RST    4'h7

`define MSC_RST_MIN_CYC 500
`define MSC_INIT_CYC    64

`endif

/* hdl/msc_pkg.sv */
package msc_pkg;
  typedef enum logic [1:0] {
    PWR_INIT,
    PWR_LOW,
    PWR_HIGH
  } msc_pwr_e;
endpackage

/* hdl/msc_sync.sv */
`timescale 1ns/1ns
module msc_sync #(
  parameter int          W       = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_r[g] <= RST_VAL[g];
          q_o[g]    <= RST_VAL[g];
        end else begin
          meta_r[g] <= d_i[g];
          q_o[g]    <= meta_r[g];
        end
      end
    end
  endgenerate
endmodule

/* hdl/msc_sideband.sv */
// Behaviour
// - Management accesses are answered only while module select is low.
// - A reset pin held low past the minimum restores all defaults.
// - Reset completion raises attention and clears the not-ready flag.
// - After power-up the completion attention is raised without a pulse.
// - An undriven init-control input reads as high (software control).
// - In software mode the module stays low power until software enables.
// - In hardware mode the module goes high power once init is done.
// - The presence line is pulled low for as long as the module is fitted.
// - Attention goes low on a fault or critical status condition.
// - Attention only pulls low or releases, never drives high.
// - The memory map is reached only over the management serial bus.
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`include "msc_cfg.svh"
module msc_sideband #(
  parameter int unsigned RST_MIN_CYC = `MSC_RST_MIN_CYC,
  parameter int unsigned INIT_CYC    = `MSC_INIT_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic            wb_ack_o,
  input  wire logic       module_select_n_i,
  input  wire logic       module_reset_n_i,
  input  wire logic       init_control_select_i,
  input  wire logic       init_control_oe_i,
  input  wire logic       fault_event_i,
  output logic            high_power_o,
  output logic            module_present_n_o,
  output logic            module_present_oe_o,
  output logic            attention_n_o,
  output logic            attention_oe_o
);
  localparam int RW = $clog2(RST_MIN_CYC + 1);
  localparam int IW = $clog2(INIT_CYC + 1);
  localparam logic [RW-1:0] RST_MIN = RW'(RST_MIN_CYC);
  localparam logic [IW-1:0] INIT_LD = IW'(INIT_CYC);

  logic [3:0] sync_q;
  logic       sel_n_s;
  logic       mod_rst_n_s;
  logic       init_sw;

  // Select, reset and init pins come from the host's domain
  msc_sync #(
    .W       (4),
    .RST_VAL (`MSC_SYNC_RST)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({init_control_oe_i, init_control_select_i,
             module_reset_n_i, module_select_n_i}),
    .q_o   (sync_q)
  );

  assign sel_n_s     = sync_q[0];
  assign mod_rst_n_s = sync_q[1];
  // Pad pull-up wins when the host leaves the pin floating
  assign init_sw     = sync_q[2] | ~sync_q[3];

  // Reset pin filter
  logic [RW-1:0] low_cnt_r;
  logic          rst_hold;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_cnt_r <= '0;
    end else if (mod_rst_n_s) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != RST_MIN) begin
      // Saturates so a long hold cannot wrap back below the limit
      low_cnt_r <= low_cnt_r + 1'b1;
    end
  end

  // Held in reset only once the low level outlasts the minimum
  assign rst_hold = ~mod_rst_n_s & (low_cnt_r == RST_MIN);

  // Power state machine
  msc_pkg::msc_pwr_e pwr_r;
  msc_pkg::msc_pwr_e pwr_nxt;
  logic [IW-1:0]     init_cnt_r;
  logic              not_ready_r;
  logic              init_done;
  logic              ctrl_hpen_r;

  assign init_done = (pwr_r == msc_pkg::PWR_INIT) && (init_cnt_r == '0);

  always_comb begin
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      msc_pkg::PWR_INIT: begin
        if (init_done) begin
          pwr_nxt = init_sw ? msc_pkg::PWR_LOW : msc_pkg::PWR_HIGH;
        end
      end
      msc_pkg::PWR_LOW: begin
        if (ctrl_hpen_r || !init_sw) begin
          pwr_nxt = msc_pkg::PWR_HIGH;
        end
      end
      msc_pkg::PWR_HIGH: begin
        if (init_sw && !ctrl_hpen_r) begin
          pwr_nxt = msc_pkg::PWR_LOW;
        end
      end
      default: begin
        pwr_nxt = msc_pkg::PWR_INIT;
      end
    endcase
    if (rst_hold) begin
      pwr_nxt = msc_pkg::PWR_INIT;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_r        <= msc_pkg::PWR_INIT;
      high_power_o <= 1'b0;
    end else begin
      pwr_r        <= pwr_nxt;
      high_power_o <= (pwr_nxt == msc_pkg::PWR_HIGH);
    end
  end

  // Power-up runs the same init as a pin reset, so completion is posted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_cnt_r  <= INIT_LD;
      not_ready_r <= 1'b1;
    end else if (rst_hold) begin
      init_cnt_r  <= INIT_LD;
      not_ready_r <= 1'b1;
    end else if (init_done) begin
      not_ready_r <= 1'b0;
    end else if (pwr_r == msc_pkg::PWR_INIT) begin
      init_cnt_r  <= init_cnt_r - 1'b1;
    end
  end

  // Register bus, classic single cycle
  logic req;
  logic wr_take;
  logic [`MSC_FLG_W-1:0] flags_r;
  logic [`MSC_FLG_W-1:0] mask_r;
  logic [`MSC_FLG_W-1:0] flag_set;
  logic [`MSC_FLG_W-1:0] flag_clr;
  logic [31:0]           rd_nxt;

  // Deselected requests wait unanswered; the bus is shared
  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~sel_n_s;
  // Only lane 0 carries register bits, other lanes alone are ignored
  assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];

  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (wb_adr_i)
      `MSC_ADDR_STATUS: begin
        rd_nxt[`MSC_ST_NRDY]   = not_ready_r;
        rd_nxt[`MSC_ST_HIGH]   = high_power_o;
        rd_nxt[`MSC_ST_HWMODE] = ~init_sw;
      end
      `MSC_ADDR_FLAGS: rd_nxt[`MSC_FLG_W-1:0] = flags_r;
      `MSC_ADDR_CTRL:  rd_nxt[`MSC_CTRL_HPEN] = ctrl_hpen_r;
      `MSC_ADDR_MASK:  rd_nxt[`MSC_FLG_W-1:0] = mask_r;
      default:         rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= rd_nxt;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || rst_hold) begin
      ctrl_hpen_r <= `MSC_CTRL_RST;
      mask_r      <= `MSC_MASK_RST;
    end else if (wr_take && wb_adr_i == `MSC_ADDR_CTRL) begin
      ctrl_hpen_r <= wb_dat_i[`MSC_CTRL_HPEN];
    end else if (wr_take && wb_adr_i == `MSC_ADDR_MASK) begin
      mask_r      <= wb_dat_i[`MSC_FLG_W-1:0];
    end
  end

  // Mask gates attention only; flags latch regardless
  // Sticky flags, write one to clear; a new event beats the clear
  always_comb begin
    flag_set                 = '0;
    flag_set[`MSC_FLG_DONE]  = init_done;
    flag_set[`MSC_FLG_FAULT] = fault_event_i;
    flag_set[`MSC_FLG_PWR]   = (pwr_nxt == msc_pkg::PWR_HIGH) &&
                               (pwr_r != msc_pkg::PWR_HIGH);
    flag_clr = '0;
    if (wr_take && wb_adr_i == `MSC_ADDR_FLAGS) begin
      flag_clr = wb_dat_i[`MSC_FLG_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || rst_hold) begin
      flags_r <= `MSC_FLAGS_RST;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
  end

  // Open drain: data always low, only the enable moves
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      attention_n_o       <= 1'b0;
      attention_oe_o      <= 1'b0;
      module_present_n_o  <= 1'b0;
      module_present_oe_o <= 1'b1;
    end else begin
      attention_n_o       <= 1'b0;
      attention_oe_o      <= |(flags_r & mask_r);
      module_present_n_o  <= 1'b0;
      module_present_oe_o <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_fault_seen;
    fault_event_i && mask_r[`MSC_FLG_FAULT] && !rst_hold;
  endsequence

  sequence s_short_low;
    $fell(mod_rst_n_s) ##1 !mod_rst_n_s [*2] ##1 mod_rst_n_s;
  endsequence

  sequence s_init_ends;
    init_done && !rst_hold;
  endsequence

  chk_select_gate: assert property (
    $rose(wb_ack_o) |-> $past(!sel_n_s))
    else $error("ack given while module deselected");

  chk_short_pulse: assert property (
    s_short_low |-> !not_ready_r || $past(not_ready_r, 3))
    else $error("short reset pulse restarted init");

  chk_reset_default: assert property (
    rst_hold |=> !ctrl_hpen_r && mask_r == `MSC_MASK_RST && not_ready_r &&
                 pwr_r == msc_pkg::PWR_INIT)
    else $error("reset did not restore defaults");

  chk_hold_clear: assert property (
    rst_hold |=> flags_r == `MSC_FLAGS_RST && !high_power_o)
    else $error("pin reset left flags or power set");

  chk_done_post: assert property (
    s_init_ends |=> !not_ready_r && flags_r[`MSC_FLG_DONE])
    else $error("reset completion not posted");

  chk_done_attn: assert property (
    s_init_ends ##0 mask_r[`MSC_FLG_DONE] ##1 !rst_hold |=> attention_oe_o)
    else $error("completion attention missing");

  chk_sw_low: assert property (
    pwr_r == msc_pkg::PWR_LOW && init_sw && !ctrl_hpen_r && !rst_hold
      |=> pwr_r == msc_pkg::PWR_LOW && !high_power_o)
    else $error("left low power without enable");

  chk_hw_high: assert property (
    s_init_ends ##0 !init_sw |=> high_power_o)
    else $error("hardware mode did not go high power");

  chk_fault_flag: assert property (
    s_fault_seen |=> flags_r[`MSC_FLG_FAULT] ##1 attention_oe_o)
    else $error("fault did not raise attention");

  chk_attn_release: assert property (
    !(|(flags_r & mask_r)) |=> !attention_oe_o)
    else $error("attention held with no pending flag");

  chk_never_high: assert property (
    !attention_n_o && !module_present_n_o && module_present_oe_o)
    else $error("open drain pin driven high");
endmodule

/* tb/msc_host_model.sv */
`timescale 1ns/1ns
module msc_host_model (
  input  wire logic clk_i,
  input  wire logic attention_n_i,
  input  wire logic attention_oe_i,
  input  wire logic present_n_i,
  input  wire logic present_oe_i,
  output logic      attention_line_o,
  output logic      present_line_o,
  output logic      select_n_o,
  output logic      reset_n_o,
  output logic      init_level_o,
  output logic      init_oe_o
);
  // Host pull-ups on both open-drain lines
  assign attention_line_o = attention_oe_i ? attention_n_i : 1'b1;
  assign present_line_o   = present_oe_i ? present_n_i : 1'b1;
  initial begin
    select_n_o   = 1'b1;
    reset_n_o    = 1'b1;
    init_oe_o    = 1'b0;
    init_level_o = 1'b0;
  end
  // Only called while the module is held in reset
  task automatic set_init(input logic drive, input logic level);
    @(posedge clk_i);
    init_oe_o    <= drive;
    init_level_o <= level;
  endtask
  task automatic select(input logic s);
    @(posedge clk_i);
    select_n_o <= s;
  endtask
  task automatic pulse_reset(input int n);
    @(posedge clk_i);
    reset_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    reset_n_o <= 1'b1;
  endtask
endmodule

/* tb/msc_sideband_tb.sv */
`timescale 1ns/1ns
module msc_sideband_tb;
  logic        clk_i, rst_i, cyc, stb, we, fault, ack, hp;
  logic        pres_n, pres_oe, att_n, att_oe, att_l, pres_l;
  logic        sel_n, rst_n, init_lv, init_oe;
  logic [7:0]  adr;
  logic [3:0]  sel, lanes;
  logic [31:0] dat, rd, dout;
  int          miscompares = 0;
  int          checks = 0;
  int          cycles = 0;
  int          waited;
  msc_sideband #(.RST_MIN_CYC(4), .INIT_CYC(8)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dout), .wb_ack_o(ack), .module_select_n_i(sel_n),
    .module_reset_n_i(rst_n), .init_control_select_i(init_lv),
    .init_control_oe_i(init_oe), .fault_event_i(fault),
    .high_power_o(hp), .module_present_n_o(pres_n),
    .module_present_oe_o(pres_oe), .attention_n_o(att_n),
    .attention_oe_o(att_oe));
  msc_host_model u_host (
    .clk_i(clk_i), .attention_n_i(att_n), .attention_oe_i(att_oe),
    .present_n_i(pres_n), .present_oe_i(pres_oe),
    .attention_line_o(att_l), .present_line_o(pres_l),
    .select_n_o(sel_n), .reset_n_o(rst_n), .init_level_o(init_lv),
    .init_oe_o(init_oe));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Hang guard well above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= lanes;
    waited = 0;
    do begin
      @(posedge clk_i);
      waited++;
    end while (ack !== 1'b1);
    q = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    dat <= ~d;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, rd);
    chk("read", e, rd);
  endtask
  task automatic line_chk(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, fault} = 4'h0;
    adr = 8'h00;
    sel = 4'h0;
    lanes = 4'hF;
    dat = 32'h0;
    idle(6);
    rst_i <= 1'b0;
    u_host.select(1'b0);
    idle(20);
    line_chk("present", 1'b0, pres_l);
    line_chk("attention", 1'b0, att_l);
    line_chk("attention_data", 1'b0, att_n);
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h04, 32'h1);
    wb(1'b1, 8'h04, 32'h1, rd);
    idle(3);
    line_chk("attention", 1'b1, att_l);
    line_chk("high_power", 1'b0, hp);
    wb(1'b1, 8'h08, 32'h1, rd);
    idle(2);
    line_chk("high_power", 1'b1, hp);
    lanes = 4'hE;
    wb(1'b1, 8'h08, 32'h0, rd);
    lanes = 4'hF;
    rd_chk(8'h08, 32'h1);
    line_chk("high_power", 1'b1, hp);
    rd_chk(8'h04, 32'h4);
    wb(1'b1, 8'h04, 32'h4, rd);
    @(posedge clk_i) fault <= ~fault;
    @(posedge clk_i) fault <= ~fault;
    idle(3);
    line_chk("attention", 1'b0, att_l);
    rd_chk(8'h04, 32'h2);
    wb(1'b1, 8'h04, 32'h2, rd);
    idle(3);
    line_chk("attention", 1'b1, att_l);
    u_host.select(1'b1);
    idle(3);
    fork
      begin
        idle(30);
        u_host.select(1'b0);
      end
    join_none
    rd_chk(8'h08, 32'h1);
    line_chk("stall", 1'b1, waited > 30);
    rd_chk(8'h10, 32'h0);
    u_host.pulse_reset(3);
    idle(20);
    line_chk("high_power", 1'b1, hp);
    u_host.pulse_reset(20);
    idle(30);
    line_chk("high_power", 1'b0, hp);
    rd_chk(8'h08, 32'h0);
    rd_chk(8'h0C, 32'h7);
    line_chk("attention", 1'b0, att_l);
    rd_chk(8'h00, 32'h0);
    rst_i <= 1'b1;
    u_host.set_init(1'b1, 1'b0);
    idle(6);
    rst_i <= 1'b0;
    idle(20);
    line_chk("high_power", 1'b1, hp);
    rd_chk(8'h00, 32'h6);
    print_verdict();
  end
endmodule
